/* File: logic/soai_pkg.sv */
package soai_pkg;

  localparam int unsigned CLK_HZ    = 50_000_000;
  localparam int unsigned BAUD_BPS  = 38_400;
  localparam int unsigned BIT_CYC   = CLK_HZ / BAUD_BPS;
  localparam int unsigned GAP_US    = 2_000;
  localparam int unsigned US_CYC    = CLK_HZ / 1_000_000;
  localparam int unsigned FRAME_LEN = 10;
  localparam int unsigned NUM_OBJ   = 10;

  // Function codes, request and reply
  localparam logic [7:0] FC_WR4   = 8'h23;
  localparam logic [7:0] FC_WR2   = 8'h2B;
  localparam logic [7:0] FC_WR1   = 8'h2F;
  localparam logic [7:0] FC_RD    = 8'h40;
  localparam logic [7:0] FC_WR_OK = 8'h60;
  localparam logic [7:0] FC_RD4   = 8'h43;
  localparam logic [7:0] FC_RD2   = 8'h4B;
  localparam logic [7:0] FC_RD1   = 8'h4F;
  localparam logic [7:0] FC_ERR   = 8'h80;

  // Error words returned in the data bytes
  localparam logic [31:0] ERR_NO_OBJ = 32'h0602_0000;
  localparam logic [31:0] ERR_RO     = 32'h0601_0002;
  localparam logic [31:0] ERR_CMD    = 32'h0504_0001;

  // Object keys: index, subindex, width in bits
  localparam logic [31:0] OBJ_KEY [NUM_OBJ] = '{
    32'h6040_0010, 32'h6060_0008, 32'h607A_0020, 32'h6081_0020, 32'h6083_0020,
    32'h6084_0020, 32'h6098_0008, 32'h6099_0120, 32'h6099_0220, 32'h60FF_0020};
  localparam logic [3:0]  IDX_CTRL   = 4'h0;
  localparam logic [3:0]  IDX_MODE   = 4'h1;
  localparam logic [31:0] STAT_KEY   = 32'h6041_0010;
  localparam logic [31:0] OBJ_RST    = 32'h0000_0000;
  localparam int unsigned REACH_BIT  = 10;

  localparam logic [7:0]  MODE_HOME  = 8'h06;
  localparam logic [7:0]  MODE_POS   = 8'h01;
  localparam logic [7:0]  MODE_VEL   = 8'h03;
  localparam logic [15:0] CW_ENABLE  = 16'h000F;
  localparam logic [15:0] CW_HOME    = 16'h001F;
  localparam logic [15:0] CW_ABS_ARM = 16'h002F;
  localparam logic [15:0] CW_ABS_GO  = 16'h003F;
  localparam logic [15:0] CW_REL_ARM = 16'h004F;
  localparam logic [15:0] CW_REL_GO  = 16'h005F;

  typedef struct packed {
    logic [7:0]  func;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] data;
  } soai_msg_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } soai_byte_t;

  typedef enum logic [1:0] {
    ST_RECV = 2'b00,
    ST_EXEC = 2'b01,
    ST_SEND = 2'b10
  } soai_state_t;

  function automatic logic [31:0] soai_mask(input logic [7:0] width);
    case (width)
      8'h08:   soai_mask = 32'h0000_00FF;
      8'h10:   soai_mask = 32'h0000_FFFF;
      default: soai_mask = 32'hFFFF_FFFF;
    endcase
  endfunction : soai_mask

endpackage : soai_pkg

/* File: logic/soai_uart_rx.sv */
`timescale 1ns/100ps
module soai_uart_rx
  import soai_pkg::*;
#(
  parameter int unsigned CYC = BIT_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic rxd,
  output soai_byte_t rx_o
);

  logic       s1_q, s2_q, busy_q, busy_d;
  logic [15:0] tmr_q, tmr_d;
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  sh_q, sh_d;
  soai_byte_t  out_q, out_d;

  always_comb begin
    busy_d = busy_q;
    tmr_d  = tmr_q;
    bit_d  = bit_q;
    sh_d   = sh_q;
    out_d  = '{valid: 1'b0, data: out_q.data};
    if (!busy_q) begin
      // Sample mid-bit: first wait is half a bit
      if (!s2_q) begin
        busy_d = 1'b1;
        tmr_d  = 16'(CYC / 2);
        bit_d  = 4'h0;
      end
    end else if (tmr_q != 16'h0) begin
      tmr_d = tmr_q - 16'h1;
    end else begin
      tmr_d = 16'(CYC - 1);
      bit_d = bit_q + 4'h1;
      if (bit_q == 4'h0) begin
        busy_d = ~s2_q;
      end else if (bit_q < 4'h9) begin
        sh_d = {s2_q, sh_q[7:1]};
      end else begin
        // A missing stop bit drops the byte
        busy_d = 1'b0;
        out_d  = '{valid: s2_q, data: sh_q};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q   <= 1'b1;
      s2_q   <= 1'b1;
      busy_q <= 1'b0;
      tmr_q  <= 16'h0;
      bit_q  <= 4'h0;
      sh_q   <= 8'h00;
      out_q  <= '0;
    end else begin
      s1_q   <= rxd;
      s2_q   <= s1_q;
      busy_q <= busy_d;
      tmr_q  <= tmr_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      out_q  <= out_d;
    end
  end

  assign rx_o = out_q;

endmodule : soai_uart_rx

/* File: logic/soai_uart_tx.sv */
`timescale 1ns/100ps
module soai_uart_tx
  import soai_pkg::*;
#(
  parameter int unsigned CYC = BIT_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  soai_byte_t tx_i,
  output logic       busy,
  output logic       txd
);

  logic        busy_q, busy_d, txd_q, txd_d;
  logic [15:0] tmr_q, tmr_d;
  logic [3:0]  bit_q, bit_d;
  logic [9:0]  sh_q, sh_d;

  always_comb begin
    busy_d = busy_q;
    tmr_d  = tmr_q;
    bit_d  = bit_q;
    sh_d   = sh_q;
    if (!busy_q) begin
      if (tx_i.valid) begin
        sh_d   = {1'b1, tx_i.data, 1'b0};
        busy_d = 1'b1;
        tmr_d  = 16'(CYC - 1);
        bit_d  = 4'h0;
      end
    end else if (tmr_q != 16'h0) begin
      tmr_d = tmr_q - 16'h1;
    end else if (bit_q == 4'h9) begin
      busy_d = 1'b0;
    end else begin
      bit_d = bit_q + 4'h1;
      sh_d  = {1'b1, sh_q[9:1]};
      tmr_d = 16'(CYC - 1);
    end
    txd_d = busy_d ? sh_d[0] : 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      txd_q  <= 1'b1;
      tmr_q  <= 16'h0;
      bit_q  <= 4'h0;
      sh_q   <= 10'h3FF;
    end else begin
      busy_q <= busy_d;
      txd_q  <= txd_d;
      tmr_q  <= tmr_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
    end
  end

  assign busy = busy_q;
  assign txd  = txd_q;

endmodule : soai_uart_tx

/* File: logic/soai_top.sv */
// Function
// - Frame is ten bytes: station, eight protocol bytes, negated-sum checksum.
// - Stay silent on a foreign station number or a bad checksum.
// - Link runs 38400 bit/s, eight data bits, one stop, no parity.
// - Successful write answers with code 60h.
// - Failed write answers 80h with error in bytes 5 to 8.
// - Every reply echoes index and subindex of the request.
// - Read reply code 43h, 4Bh or 4Fh by object width.
// - Failed read, missing object included, answers 80h with error data.
// - Reading a missing object reports an error.
// - Data bytes carry the value least significant byte first.
// - After a failed read the data bytes are not the object value.
// - Status bit 10 shows target position reached.
`timescale 1ns/100ps
module soai_top
  import soai_pkg::*;
#(
  parameter int unsigned GAP_CYC  = GAP_US * US_CYC,
  // Bit time in clocks; a bench may shorten it to keep runs brief
  parameter int unsigned BAUD_CYC = BIT_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       RXD,
  input  wire logic [7:0] STATION_ID,
  input  wire logic       TARGET_REACHED,
  output logic            TXD,
  output logic [15:0]     DRIVE_CTRL,
  output logic [7:0]      OP_MODE,
  output logic            HOME_START,
  output logic            MOVE_ABS,
  output logic            MOVE_REL
);

  localparam int GW = $clog2(GAP_CYC + 1);

  logic [7:0]   id_s1_q, id_s2_q;
  logic         tr_s1_q, tr_s2_q;

  soai_state_t  state_q, state_d;
  logic [7:0]   buf_q [FRAME_LEN];
  logic [7:0]   buf_d [FRAME_LEN];
  logic [3:0]   cnt_q, cnt_d;
  logic [7:0]   sum_q, sum_d;
  logic [GW-1:0] gap_q, gap_d;
  logic [3:0]   snd_q, snd_d;
  logic [7:0]   tsum_q, tsum_d;

  logic [31:0]  obj_q [NUM_OBJ];
  logic [31:0]  obj_d [NUM_OBJ];
  soai_msg_t    rsp_q, rsp_d;
  logic         home_q, home_d;
  logic         abs_q, abs_d;
  logic         rel_q, rel_d;

  soai_byte_t   rx;
  soai_byte_t   tx;
  logic         tx_busy;
  logic [7:0]   tx_byte;
  soai_msg_t    req;
  logic         hit, is_stat, wr_cmd, rd_cmd;
  logic [3:0]   hidx;
  logic [7:0]   wid;
  logic [15:0]  stat;

  // Pins cross into the clock domain through two stages
  always_ff @(posedge CLK) begin
    if (RST) begin
      id_s1_q <= 8'h00;
      id_s2_q <= 8'h00;
      tr_s1_q <= 1'b0;
      tr_s2_q <= 1'b0;
    end else begin
      id_s1_q <= STATION_ID;
      id_s2_q <= id_s1_q;
      tr_s1_q <= TARGET_REACHED;
      tr_s2_q <= tr_s1_q;
    end
  end

  soai_uart_rx #(.CYC(BAUD_CYC)) soai_uart_rx_inst (
    .clk  (CLK),
    .rst  (RST),
    .rxd  (RXD),
    .rx_o (rx)
  );

  soai_uart_tx #(.CYC(BAUD_CYC)) soai_uart_tx_inst (
    .clk  (CLK),
    .rst  (RST),
    .tx_i (tx),
    .busy (tx_busy),
    .txd  (TXD)
  );

  // low byte first in the data field
  assign req     = {buf_q[1], buf_q[3], buf_q[2], buf_q[4], buf_q[8], buf_q[7], buf_q[6], buf_q[5]};
  assign wr_cmd  = (req.func == FC_WR4) || (req.func == FC_WR2) || (req.func == FC_WR1);
  assign rd_cmd  = (req.func == FC_RD);
  assign is_stat = ({req.index, req.sub} == STAT_KEY[31:8]);
  assign wid     = OBJ_KEY[hidx][7:0];

  always_comb begin
    hit  = 1'b0;
    hidx = 4'h0;
    for (int i = 0; i < NUM_OBJ; i++) begin
      if (OBJ_KEY[i][31:8] == {req.index, req.sub}) begin
        hit  = 1'b1;
        hidx = 4'(i);
      end
    end
  end

  // target reached in status bit 10
  always_comb begin
    stat            = 16'h0000;
    stat[REACH_BIT] = tr_s2_q;
  end

  always_comb begin
    case (snd_q)
      4'h0:    tx_byte = id_s2_q;
      4'h1:    tx_byte = rsp_q.func;
      4'h2:    tx_byte = rsp_q.index[7:0];
      4'h3:    tx_byte = rsp_q.index[15:8];
      4'h4:    tx_byte = rsp_q.sub;
      4'h5:    tx_byte = rsp_q.data[7:0];
      4'h6:    tx_byte = rsp_q.data[15:8];
      4'h7:    tx_byte = rsp_q.data[23:16];
      4'h8:    tx_byte = rsp_q.data[31:24];
      4'h9:    tx_byte = 8'h00 - tsum_q;
      default: tx_byte = 8'h00;
    endcase
  end

  // Frame sequencing: collect, execute, reply
  always_comb begin
    state_d = state_q;
    buf_d   = buf_q;
    cnt_d   = cnt_q;
    sum_d   = sum_q;
    gap_d   = gap_q;
    snd_d   = snd_q;
    tsum_d  = tsum_q;
    tx      = '{valid: 1'b0, data: tx_byte};
    case (state_q)
      ST_RECV: begin
        if (rx.valid) begin
          buf_d[cnt_q] = rx.data;
          gap_d        = '0;
          if (cnt_q == 4'(FRAME_LEN - 1)) begin
            cnt_d = 4'h0;
            sum_d = 8'h00;
            // foreign station or bad checksum stays silent
            if (buf_q[0] == id_s2_q && 8'(sum_q + rx.data) == 8'h00) begin
              state_d = ST_EXEC;
            end
          end else begin
            cnt_d = cnt_q + 4'h1;
            sum_d = sum_q + rx.data;
          end
        end else if (cnt_q != 4'h0) begin
          // A long pause drops a partial frame so a lost byte cannot skew the next one
          if (gap_q == GW'(GAP_CYC - 1)) begin
            cnt_d = 4'h0;
            sum_d = 8'h00;
            gap_d = '0;
          end else begin
            gap_d = gap_q + 1'b1;
          end
        end
      end
      ST_EXEC: begin
        state_d = ST_SEND;
        snd_d   = 4'h0;
        tsum_d  = 8'h00;
      end
      ST_SEND: begin
        // Bytes arriving while the reply goes out are discarded
        if (!tx_busy) begin
          if (snd_q == 4'(FRAME_LEN)) begin
            state_d = ST_RECV;
          end else begin
            tx.valid = 1'b1;
            snd_d    = snd_q + 4'h1;
            tsum_d   = tsum_q + tx_byte;
          end
        end
      end
      default: begin
        state_d = ST_RECV;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= ST_RECV;
      cnt_q   <= 4'h0;
      sum_q   <= 8'h00;
      gap_q   <= '0;
      snd_q   <= 4'h0;
      tsum_q  <= 8'h00;
      for (int i = 0; i < FRAME_LEN; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else begin
      state_q <= state_d;
      buf_q   <= buf_d;
      cnt_q   <= cnt_d;
      sum_q   <= sum_d;
      gap_q   <= gap_d;
      snd_q   <= snd_d;
      tsum_q  <= tsum_d;
    end
  end

  // Object access and motion start decoding
  always_comb begin
    obj_d  = obj_q;
    rsp_d  = rsp_q;
    home_d = 1'b0;
    abs_d  = 1'b0;
    rel_d  = 1'b0;
    if (state_q == ST_EXEC) begin
      rsp_d.index = req.index;
      rsp_d.sub   = req.sub;
      if (rd_cmd) begin
        if (hit) begin
          rsp_d.func = (wid == 8'h20) ? FC_RD4 : (wid == 8'h10) ? FC_RD2 : FC_RD1;
          rsp_d.data = obj_q[hidx];
        end else if (is_stat) begin
          rsp_d.func = FC_RD2;
          rsp_d.data = {16'h0000, stat};
        end else begin
          rsp_d.func = FC_ERR;
          rsp_d.data = ERR_NO_OBJ;
        end
      end else if (wr_cmd) begin
        if (hit) begin
          obj_d[hidx] = req.data & soai_mask(wid);
          rsp_d.func  = FC_WR_OK;
          // Data bytes are kept: the reply carries the written value back
          rsp_d.data  = req.data;
          if (hidx == IDX_CTRL) begin
            // edge of the control word starts the move
            home_d = obj_q[IDX_MODE][7:0] == MODE_HOME && obj_q[IDX_CTRL][15:0] == CW_ENABLE
                     && req.data[15:0] == CW_HOME;
            abs_d  = obj_q[IDX_MODE][7:0] == MODE_POS && obj_q[IDX_CTRL][15:0] == CW_ABS_ARM
                     && req.data[15:0] == CW_ABS_GO;
            rel_d  = obj_q[IDX_MODE][7:0] == MODE_POS && obj_q[IDX_CTRL][15:0] == CW_REL_ARM
                     && req.data[15:0] == CW_REL_GO;
          end
        end else begin
          rsp_d.func = FC_ERR;
          rsp_d.data = is_stat ? ERR_RO : ERR_NO_OBJ;
        end
      end else begin
        rsp_d.func = FC_ERR;
        rsp_d.data = ERR_CMD;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rsp_q  <= '0;
      home_q <= 1'b0;
      abs_q  <= 1'b0;
      rel_q  <= 1'b0;
      for (int i = 0; i < NUM_OBJ; i++) begin
        obj_q[i] <= OBJ_RST;
      end
    end else begin
      obj_q  <= obj_d;
      rsp_q  <= rsp_d;
      home_q <= home_d;
      abs_q  <= abs_d;
      rel_q  <= rel_d;
    end
  end

  assign DRIVE_CTRL = obj_q[IDX_CTRL][15:0];
  assign OP_MODE    = obj_q[IDX_MODE][7:0];
  assign HOME_START = home_q;
  assign MOVE_ABS   = abs_q;
  assign MOVE_REL   = rel_q;

  // Checking: running sum of every sent byte must close at zero
  logic [7:0] chk_sum_q;

  always_ff @(posedge CLK) begin
    if (RST || state_q == ST_EXEC) begin
      chk_sum_q <= 8'h00;
    end else if (tx.valid) begin
      chk_sum_q <= chk_sum_q + tx.data;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence seq_abs_cmd;
    state_q == ST_EXEC && wr_cmd && hit && hidx == IDX_CTRL && OP_MODE == MODE_POS;
  endsequence

  sequence seq_abs_pulse;
    MOVE_ABS ##1 !MOVE_ABS;
  endsequence

  chk_frame_cksum: assert property (
    state_q == ST_SEND && !tx_busy && snd_q == 4'hA |-> chk_sum_q == 8'h00)
    else $error("reply checksum does not close");

  chk_silent_bad_id: assert property (
    state_q == ST_RECV && rx.valid && cnt_q == 4'h9 && buf_q[0] != id_s2_q |=> state_q == ST_RECV)
    else $error("answered a foreign station");

  chk_write_ok_code: assert property (
    state_q == ST_EXEC && wr_cmd && hit |=> rsp_q.func == FC_WR_OK ##1 state_q == ST_SEND)
    else $error("write not answered with 60h");

  chk_write_err_code: assert property (
    state_q == ST_EXEC && wr_cmd && !hit |=> rsp_q.func == FC_ERR && rsp_q.data != 32'h0)
    else $error("failed write not answered with 80h");

  chk_echo_address: assert property (
    state_q == ST_EXEC |=> rsp_q.index == $past(req.index) && rsp_q.sub == $past(req.sub))
    else $error("index or subindex not echoed");

  chk_read_width: assert property (
    state_q == ST_EXEC && rd_cmd && hit && wid == 8'h08 |=> rsp_q.func == FC_RD1)
    else $error("byte object read with wrong code");

  chk_read_missing: assert property (
    state_q == ST_EXEC && rd_cmd && !hit && !is_stat |=> rsp_q.func == FC_ERR && rsp_q.data == ERR_NO_OBJ)
    else $error("missing object read not refused");

  chk_data_lsb_first: assert property (
    tx.valid && snd_q == 4'h5 |-> tx.data == rsp_q.data[7:0] ##1 snd_q == 4'h6)
    else $error("data byte order wrong");

  chk_status_reach: assert property (
    state_q == ST_EXEC && rd_cmd && is_stat |=> rsp_q.data[10] == $past(tr_s2_q))
    else $error("status bit 10 does not follow target reached");

  chk_abs_move_start: assert property (
    seq_abs_cmd ##0 (DRIVE_CTRL == CW_ABS_ARM && req.data[15:0] == CW_ABS_GO) |=> seq_abs_pulse)
    else $error("absolute move not started");

endmodule : soai_top

/* File: bench/soai_host_model.sv */
`timescale 1ns/100ps
module soai_host_model
  import soai_pkg::*;
#(
  parameter int unsigned CYC = BIT_CYC
) (
  input  wire logic clk,
  output logic      rxd,
  input  wire logic txd
);
  initial rxd = 1'b1;

  // 8N1, LSB first; stop bit held for stop_cyc
  task automatic send_byte(input logic [7:0] b, input int unsigned stop_cyc);
    logic [8:0] sh;
    sh = {b, 1'b0};
    for (int i = 0; i < 9; i++) begin
      rxd = sh[i];
      repeat (CYC) @(posedge clk);
      #1;
    end
    rxd = 1'b1;
    repeat (stop_cyc) @(posedge clk);
    #1;
  endtask : send_byte

  // ten bytes back to back
  // Idle bit time first so the previous reply has fully ended;
  // last stop bit cut short since the reply starts mid stop bit
  task automatic send_frame(input logic [7:0] f[10]);
    repeat (CYC) @(posedge clk);
    #1;
    for (int k = 0; k < 10; k++) send_byte(f[k], (k == 9) ? CYC / 4 : CYC);
  endtask : send_frame

  // caller waits for reply or timeout
  task automatic recv_frame(output logic [7:0] f[10], output logic ok, input int unsigned wait_cyc);
    int unsigned n;
    ok = 1'b1;
    for (int k = 0; k < 10; k++) begin
      n = 0;
      while (txd !== 1'b0 && n < wait_cyc) begin
        @(posedge clk);
        n++;
      end
      if (txd !== 1'b0) begin
        ok = 1'b0;
        return;
      end
      // Sample mid bit so edge jitter of a few cycles cannot matter
      repeat (CYC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (CYC) @(posedge clk);
        f[k][i] = txd;
      end
      repeat (CYC) @(posedge clk);
      if (txd !== 1'b1) ok = 1'b0;
    end
  endtask : recv_frame
endmodule : soai_host_model

/* File: bench/test_soai_top.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t mismatch got %0h exp %0h", $time, (g), (e)); end end
module test_soai_top
  import soai_pkg::*;
();
  // Fast bit time keeps the run short; the gap must exceed one character
  localparam int unsigned BITC = 12;
  localparam int unsigned GAP  = 2 * 10 * BITC;

  logic        clk;
  logic        rst;
  logic        rxd;
  logic [7:0]  station_id;
  logic        target_reached;
  logic        txd;
  logic [15:0] drive_ctrl;
  logic [7:0]  op_mode;
  logic        home_start;
  logic        move_abs;
  logic        move_rel;
  int          mismatches = 0;
  int          checked = 0;
  int          home_n = 0;
  int          abs_n = 0;
  int          rel_n = 0;

  soai_top #(.GAP_CYC(GAP), .BAUD_CYC(BITC)) soai_top_inst (
    .CLK           (clk),
    .RST           (rst),
    .RXD           (rxd),
    .STATION_ID    (station_id),
    .TARGET_REACHED(target_reached),
    .TXD           (txd),
    .DRIVE_CTRL    (drive_ctrl),
    .OP_MODE       (op_mode),
    .HOME_START    (home_start),
    .MOVE_ABS      (move_abs),
    .MOVE_REL      (move_rel)
  );

  soai_host_model #(.CYC(BITC)) soai_host_model_inst (
    .clk(clk),
    .rxd(rxd),
    .txd(txd)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // A stuck pulse counts once per cycle, so a count of one also proves width
  always @(posedge clk) begin
    if (home_start === 1'b1) home_n++;
    if (move_abs === 1'b1) abs_n++;
    if (move_rel === 1'b1) rel_n++;
  end

  function automatic void build(input logic [7:0] stn, input soai_msg_t m, output logic [7:0] f[10]);
    logic [7:0] s;
    f[0] = stn;
    f[1] = m.func;
    f[2] = m.index[7:0];
    f[3] = m.index[15:8];
    f[4] = m.sub;
    for (int i = 0; i < 4; i++) f[5+i] = m.data[8*i +: 8];
    s = 8'h00;
    for (int i = 0; i < 9; i++) s += f[i];
    f[9] = 8'h00 - s;
  endfunction : build

  task automatic xact(input soai_msg_t req, input logic [7:0] efn, input logic [31:0] edat);
    logic [7:0]  tx[10];
    logic [7:0]  ex[10];
    logic [7:0]  rx[10];
    logic        ok;
    logic [31:0] ed;
    // A write reply keeps the request's data bytes
    ed = (efn == FC_WR_OK) ? req.data : edat;
    build(8'h01, req, tx);
    build(8'h01, soai_msg_t'{efn, req.index, req.sub, ed}, ex);
    soai_host_model_inst.send_frame(tx);
    soai_host_model_inst.recv_frame(rx, ok, 2 * BITC);
    `CHK(ok, 1'b1)
    for (int i = 0; i < 10; i++) `CHK(rx[i], ex[i])
  endtask : xact

  task automatic t_silent();
    logic [7:0] tx[10];
    logic [7:0] rx[10];
    logic       ok;
    build(8'h02, soai_msg_t'{FC_WR2, 16'h6040, 8'h00, 32'h0000_00AA}, tx);
    soai_host_model_inst.send_frame(tx);
    soai_host_model_inst.recv_frame(rx, ok, 2 * BITC);
    `CHK(ok, 1'b0)
    build(8'h01, soai_msg_t'{FC_WR2, 16'h6040, 8'h00, 32'h0000_00AA}, tx);
    tx[9] = tx[9] ^ 8'h01;
    soai_host_model_inst.send_frame(tx);
    soai_host_model_inst.recv_frame(rx, ok, 2 * BITC);
    `CHK(ok, 1'b0)
    `CHK(drive_ctrl, 16'h0000)
  endtask : t_silent

  task automatic t_homing();
    xact(soai_msg_t'{FC_WR1, 16'h6060, 8'h00, 32'h6}, FC_WR_OK, 32'h0);
    xact(soai_msg_t'{FC_WR2, 16'h6040, 8'h00, 32'hF}, FC_WR_OK, 32'h0);
    xact(soai_msg_t'{FC_WR1, 16'h6098, 8'h00, 32'h21}, FC_WR_OK, 32'h0);
    `CHK(home_n, 0)
    xact(soai_msg_t'{FC_WR2, 16'h6040, 8'h00, 32'h1F}, FC_WR_OK, 32'h0);
    `CHK(home_n, 1)
    `CHK(op_mode, MODE_HOME)
    `CHK(drive_ctrl, CW_HOME)
  endtask : t_homing

  task automatic t_position();
    xact(soai_msg_t'{FC_WR1, 16'h6060, 8'h00, 32'h1}, FC_WR_OK, 32'h0);
    xact(soai_msg_t'{FC_WR4, 16'h607A, 8'h00, 32'hC350}, FC_WR_OK, 32'h0);
    xact(soai_msg_t'{FC_WR2, 16'h6040, 8'h00, 32'h2F}, FC_WR_OK, 32'h0);
    xact(soai_msg_t'{FC_WR2, 16'h6040, 8'h00, 32'h3F}, FC_WR_OK, 32'h0);
    `CHK(abs_n, 1)
    xact(soai_msg_t'{FC_WR2, 16'h6040, 8'h00, 32'h4F}, FC_WR_OK, 32'h0);
    xact(soai_msg_t'{FC_WR2, 16'h6040, 8'h00, 32'h5F}, FC_WR_OK, 32'h0);
    `CHK(rel_n, 1)
    `CHK(abs_n, 1)
    `CHK(home_n, 1)
    xact(soai_msg_t'{FC_RD, 16'h607A, 8'h00, 32'h0}, FC_RD4, 32'hC350);
    xact(soai_msg_t'{FC_RD, 16'h6060, 8'h00, 32'h0}, FC_RD1, 32'h1);
    xact(soai_msg_t'{FC_RD, 16'h6040, 8'h00, 32'h0}, FC_RD2, 32'h5F);
  endtask : t_position

  task automatic t_velocity();
    xact(soai_msg_t'{FC_WR1, 16'h6060, 8'h00, 32'h3}, FC_WR_OK, 32'h0);
    `CHK(op_mode, MODE_VEL)
    xact(soai_msg_t'{FC_WR4, 16'h60FF, 8'h00, 32'hFFE4_B17E}, FC_WR_OK, 32'h0);
    xact(soai_msg_t'{FC_RD, 16'h60FF, 8'h00, 32'h0}, FC_RD4, 32'hFFE4_B17E);
    xact(soai_msg_t'{FC_WR4, 16'h6083, 8'h00, 32'h0001_A36E}, FC_WR_OK, 32'h0);
    xact(soai_msg_t'{FC_RD, 16'h6083, 8'h00, 32'h0}, FC_RD4, 32'h0001_A36E);
  endtask : t_velocity

  task automatic t_errors();
    xact(soai_msg_t'{FC_RD, 16'h1234, 8'h05, 32'h0}, FC_ERR, ERR_NO_OBJ);
    xact(soai_msg_t'{FC_RD, 16'h6099, 8'h03, 32'h0}, FC_ERR, ERR_NO_OBJ);
    xact(soai_msg_t'{FC_WR2, 16'h6041, 8'h00, 32'h1}, FC_ERR, ERR_RO);
    xact(soai_msg_t'{8'h55, 16'h6040, 8'h00, 32'h0}, FC_ERR, ERR_CMD);
    xact(soai_msg_t'{FC_RD, 16'h6041, 8'h00, 32'h0}, FC_RD2, 32'h0400);
    // Both levels of the input, so a stuck status bit shows
    @(posedge clk);
    #1;
    target_reached = 1'b0;
    xact(soai_msg_t'{FC_RD, 16'h6041, 8'h00, 32'h0}, FC_RD2, 32'h0000);
  endtask : t_errors

  task automatic final_report();
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // About 2.5k cycles per frame pair at the bench bit time, under 30 pairs
  initial begin
    repeat (90_000) @(posedge clk);
    mismatches++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    station_id = 8'h01;
    target_reached = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk);
    `CHK(txd, 1'b1)
    t_silent();
    t_homing();
    t_position();
    t_velocity();
    t_errors();
    final_report();
  end
endmodule : test_soai_top
